// [hw/psl_strap_latch.v]
// strap configuration capture and holding latches with apb access
//
// Behaviour
// - rate-and-mode resistor code picks one of eight slew rates
// - mode bit 7 from rate-and-mode voltage selects older or newer code table
// - mode bit 6 selects paired or individual four-phase interleaving
// - mode bit 4 enables dynamic phase add and drop
// - mode bit 3 selects zero or non-zero load-line
// - shoot-reduction resistor code gives seven overshoot thresholds or off
// - shoot-reduction voltage code gives seven undershoot levels or off
// - boot code bits 3:1 from resistor, bits 7:4 from voltage
// - address-and-rise resistor bits 2:1 rise rate, bit 0 boot lsb
// - address-and-rise voltage gives four-bit bus address
// - frequency-and-current resistor code selects switching frequency
// - frequency-and-current voltage is eight-bit max current, 255 at reference
// - limit-and-ramp resistor and voltage codes select one of sixteen limits
// - limit-and-ramp voltage selects one of four ramp levels
// - all settings are captured when the logic supply comes up
// - large strap-select resistor takes settings from nonvolatile memory instead
// - host may overwrite latched settings; bus address stays strap only
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "psl_defs.vh"
module psl_strap_latch (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire logic_supply_rail,
  input wire strap_source_select,
  input wire [2:0] rate_mode_res_code,
  input wire [3:0] rate_mode_volt_code,
  input wire [2:0] shoot_reduction_strap_res,
  input wire [2:0] shoot_reduction_strap_volt,
  input wire [2:0] startup_voltage_strap_res,
  input wire [3:0] startup_voltage_strap_volt,
  input wire [2:0] address_and_rise_strap_res,
  input wire [3:0] address_and_rise_strap_volt,
  input wire [2:0] frequency_and_current_strap_res,
  input wire [7:0] frequency_and_current_strap_volt,
  input wire [2:0] limit_and_ramp_strap_res,
  input wire [1:0] limit_and_ramp_strap_volt,
  input wire [2:0] nvm_slew,
  input wire [3:0] nvm_mode,
  input wire [2:0] nvm_osr,
  input wire [2:0] nvm_usr,
  input wire [7:0] nvm_boot,
  input wire [1:0] nvm_rise,
  input wire [2:0] nvm_freq,
  input wire [7:0] nvm_max_load_current,
  input wire [3:0] nvm_limit,
  input wire [1:0] nvm_ramp,
  output reg [2:0] slew_rate_sel,
  output reg [3:0] mode_bits,
  output reg [2:0] overshoot_reduction,
  output reg [2:0] undershoot_reduction,
  output reg [7:0] voltage_id_code,
  output reg [1:0] softstart_rise_rate,
  output reg [3:0] bus_address,
  output reg [2:0] switching_freq_sel,
  output reg [7:0] max_load_current,
  output reg [3:0] per_phase_valley_limit,
  output reg [1:0] ramp_level,
  output reg config_valid
);
  ////////////////////////////////////////////////////////////////////////////
  // decode helpers
  // the limit index joins the resistor code (high) and voltage code (low):
  // 3 resistor bits and the upper voltage bit give sixteen levels
  function [3:0] limit_index;
    input [2:0] res;
    input [1:0] volt;
    begin
      limit_index = {res, volt[1]};
    end
  endfunction

  function match;
    input [11:0] addr;
    input [11:0] off;
    begin
      match = (addr == off);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // supply detection
  wire capture_pulse;
  wire supply_up;
  reg ctrl_recapture_reg;
  reg from_nvm_reg;
  reg host_wrote_reg;

  psl_supply_detect u_detect (
    .pclk(pclk),
    .presetn(presetn),
    .supply_good(logic_supply_rail),
    .rearm(ctrl_recapture_reg),
    .capture_pulse(capture_pulse),
    .supply_up(supply_up)
  );

  ////////////////////////////////////////////////////////////////////////////
  // strap decode into candidate fields
  wire [2:0] dec_slew = rate_mode_res_code;
  wire [3:0] dec_mode = {rate_mode_volt_code[3], rate_mode_volt_code[2],
    rate_mode_volt_code[1], rate_mode_volt_code[0]};
  wire [2:0] dec_osr = shoot_reduction_strap_res;
  wire [2:0] dec_usr = shoot_reduction_strap_volt;
  wire [7:0] dec_boot = {startup_voltage_strap_volt, startup_voltage_strap_res,
    address_and_rise_strap_res[0]};
  wire [1:0] dec_rise = address_and_rise_strap_res[2:1];
  wire [2:0] dec_freq = frequency_and_current_strap_res;
  wire [7:0] dec_max_load_current = frequency_and_current_strap_volt;
  wire [3:0] dec_limit = limit_index(limit_and_ramp_strap_res, limit_and_ramp_strap_volt);
  wire [1:0] dec_ramp = limit_and_ramp_strap_volt;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  wire setup_wr = psel & ~penable & pwrite;
  wire acc = psel & penable;
  wire acc_wr = acc & pwrite;
  wire hit_ctrl = match(paddr, `PSL_OFF_CTRL);
  wire hit_rate = match(paddr, `PSL_OFF_RATE_MODE);
  wire hit_shoot = match(paddr, `PSL_OFF_SHOOT);
  wire hit_boot = match(paddr, `PSL_OFF_BOOT);
  wire hit_rise = match(paddr, `PSL_OFF_RISE_ADDR);
  wire hit_fimax = match(paddr, `PSL_OFF_FREQ_MAX_LOAD_CURRENT);
  wire hit_limit = match(paddr, `PSL_OFF_LIMIT_RAMP);
  wire hit_any = hit_ctrl | hit_rate | hit_shoot | hit_boot | hit_rise | hit_fimax | hit_limit |
    match(paddr, `PSL_OFF_STATUS) | match(paddr, `PSL_OFF_RAW_CODE);
  // a write commits only at the edge that completes the transfer
  wire wr_ok = acc_wr & pready;

  ////////////////////////////////////////////////////////////////////////////
  // holding latches: next values first, then one flop bank
  // per-register write strobes; the rise-and-address strobe writes only the rise rate, so the bus address stays strap only
  wire wr_rate = wr_ok & hit_rate;
  wire wr_shoot = wr_ok & hit_shoot;
  wire wr_boot = wr_ok & hit_boot;
  wire wr_rise = wr_ok & hit_rise;
  wire wr_fimax = wr_ok & hit_fimax;
  wire wr_limit = wr_ok & hit_limit;
  wire wr_field = wr_rate | wr_shoot | wr_boot | wr_rise | wr_fimax | wr_limit;
  reg [2:0] slew_next;
  reg [3:0] mode_next;
  reg [2:0] osr_next;
  reg [2:0] usr_next;
  reg [7:0] boot_next;
  reg [1:0] rise_next;
  reg [3:0] addr_next;
  reg [2:0] freq_next;
  reg [7:0] max_load_current_next;
  reg [3:0] limit_next;
  reg [1:0] ramp_next;
  reg valid_next;
  reg from_nvm_next;
  reg host_wrote_next;

  always @* begin
    slew_next = slew_rate_sel;
    mode_next = mode_bits;
    osr_next = overshoot_reduction;
    usr_next = undershoot_reduction;
    boot_next = voltage_id_code;
    rise_next = softstart_rise_rate;
    addr_next = bus_address;
    freq_next = switching_freq_sel;
    max_load_current_next = max_load_current;
    limit_next = per_phase_valley_limit;
    ramp_next = ramp_level;
    valid_next = config_valid;
    from_nvm_next = from_nvm_reg;
    host_wrote_next = host_wrote_reg;
    // capture happens once per supply rise and again after each recapture request; in between strap pins are not looked at
    if (capture_pulse) begin
      valid_next = 1'b1;
      host_wrote_next = 1'b0;
      addr_next = address_and_rise_strap_volt;
      from_nvm_next = strap_source_select;
      if (strap_source_select) begin
        slew_next = nvm_slew;
        mode_next = nvm_mode;
        osr_next = nvm_osr;
        usr_next = nvm_usr;
        boot_next = nvm_boot;
        rise_next = nvm_rise;
        freq_next = nvm_freq;
        max_load_current_next = nvm_max_load_current;
        limit_next = nvm_limit;
        ramp_next = nvm_ramp;
      end else begin
        slew_next = dec_slew;
        mode_next = dec_mode;
        osr_next = dec_osr;
        usr_next = dec_usr;
        boot_next = dec_boot;
        rise_next = dec_rise;
        freq_next = dec_freq;
        max_load_current_next = dec_max_load_current;
        limit_next = dec_limit;
        ramp_next = dec_ramp;
      end
    end else begin
      // host overwrite loses to a capture in the same cycle
      if (wr_rate) begin
        slew_next = pwdata[`PSL_SLEW_LSB +: 3];
        mode_next = pwdata[`PSL_MODE_B3 +: 4];
      end
      if (wr_shoot) begin
        osr_next = pwdata[2:0];
        usr_next = pwdata[`PSL_USR_LSB +: 3];
      end
      if (wr_boot) begin
        boot_next = pwdata[7:0];
      end
      if (wr_rise) begin
        rise_next = pwdata[1:0];
      end
      if (wr_fimax) begin
        freq_next = pwdata[2:0];
        max_load_current_next = pwdata[`PSL_MAX_LOAD_CURRENT_LSB +: 8];
      end
      if (wr_limit) begin
        limit_next = pwdata[3:0];
        ramp_next = pwdata[`PSL_RAMP_LSB +: 2];
      end
      if (wr_field) begin
        host_wrote_next = 1'b1;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slew_rate_sel <= `PSL_RST_SLEW;
      mode_bits <= `PSL_RST_MODE;
      overshoot_reduction <= `PSL_RST_OSR;
      undershoot_reduction <= `PSL_RST_USR;
      voltage_id_code <= `PSL_RST_BOOT;
      softstart_rise_rate <= `PSL_RST_RISE;
      bus_address <= 4'h0;
      switching_freq_sel <= `PSL_RST_FREQ;
      max_load_current <= `PSL_RST_MAX_LOAD_CURRENT;
      per_phase_valley_limit <= `PSL_RST_LIMIT;
      ramp_level <= `PSL_RST_RAMP;
      config_valid <= 1'b0;
      from_nvm_reg <= 1'b0;
      host_wrote_reg <= 1'b0;
    end else begin
      slew_rate_sel <= slew_next;
      mode_bits <= mode_next;
      overshoot_reduction <= osr_next;
      undershoot_reduction <= usr_next;
      voltage_id_code <= boot_next;
      softstart_rise_rate <= rise_next;
      bus_address <= addr_next;
      switching_freq_sel <= freq_next;
      max_load_current <= max_load_current_next;
      per_phase_valley_limit <= limit_next;
      ramp_level <= ramp_next;
      config_valid <= valid_next;
      from_nvm_reg <= from_nvm_next;
      host_wrote_reg <= host_wrote_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register: recapture is a self clearing pulse
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_recapture_reg <= 1'b0;
    end else begin
      ctrl_recapture_reg <= wr_ok & hit_ctrl & pwdata[`PSL_CTRL_RECAPTURE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb read mux and answer; one wait state so every access takes two cycles after setup
  reg [31:0] rdata_next;
  always @* begin
    rdata_next = 32'h00000000;
    case (paddr)
      `PSL_OFF_STATUS: begin
        rdata_next[`PSL_STAT_CAPTURED] = config_valid;
        rdata_next[`PSL_STAT_FROM_NVM] = from_nvm_reg;
        rdata_next[`PSL_STAT_HOST_WROTE] = host_wrote_reg;
        rdata_next[`PSL_STAT_SUPPLY_UP] = supply_up;
      end
      `PSL_OFF_RATE_MODE: begin
        rdata_next[`PSL_SLEW_LSB +: 3] = slew_rate_sel;
        rdata_next[`PSL_MODE_B3 +: 4] = mode_bits;
      end
      `PSL_OFF_SHOOT: begin
        rdata_next[2:0] = overshoot_reduction;
        rdata_next[`PSL_USR_LSB +: 3] = undershoot_reduction;
      end
      `PSL_OFF_BOOT: begin
        rdata_next[7:0] = voltage_id_code;
      end
      `PSL_OFF_RISE_ADDR: begin
        rdata_next[1:0] = softstart_rise_rate;
        rdata_next[`PSL_ADDR_LSB +: 4] = bus_address;
      end
      `PSL_OFF_FREQ_MAX_LOAD_CURRENT: begin
        rdata_next[2:0] = switching_freq_sel;
        rdata_next[`PSL_MAX_LOAD_CURRENT_LSB +: 8] = max_load_current;
      end
      `PSL_OFF_LIMIT_RAMP: begin
        rdata_next[3:0] = per_phase_valley_limit;
        rdata_next[`PSL_RAMP_LSB +: 2] = ramp_level;
      end
      `PSL_OFF_RAW_CODE: begin
        rdata_next[2:0] = limit_and_ramp_strap_res;
        rdata_next[5:4] = limit_and_ramp_strap_volt;
        rdata_next[15:8] = frequency_and_current_strap_volt;
        rdata_next[19:16] = address_and_rise_strap_volt;
      end
      default: begin
        rdata_next = 32'h00000000;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      if (acc & ~pready) begin
        pready <= 1'b1;
        // unmapped addresses and writes to read-only words answer with an error
        pslverr <= ~hit_any | (pwrite & ~(hit_ctrl | hit_rate | hit_shoot | hit_boot |
          hit_rise | hit_fimax | hit_limit));
        prdata <= pwrite ? 32'h00000000 : rdata_next;
      end else begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        if (setup_wr) begin
          prdata <= 32'h00000000;
        end
      end
    end
  end
endmodule // psl_strap_latch

// [hw/psl_defs.vh]
// register map, field positions, reset values and widths for the strap latch
`ifndef PSL_DEFS_VH
`define PSL_DEFS_VH
`define PSL_ADDR_W 12
`define PSL_OFF_CTRL 12'h000
`define PSL_OFF_STATUS 12'h004
`define PSL_OFF_RATE_MODE 12'h008
`define PSL_OFF_SHOOT 12'h00C
`define PSL_OFF_BOOT 12'h010
`define PSL_OFF_RISE_ADDR 12'h014
`define PSL_OFF_FREQ_MAX_LOAD_CURRENT 12'h018
`define PSL_OFF_LIMIT_RAMP 12'h01C
`define PSL_OFF_RAW_CODE 12'h020
`define PSL_CTRL_RECAPTURE 0
`define PSL_STAT_CAPTURED 0
`define PSL_STAT_FROM_NVM 1
`define PSL_STAT_HOST_WROTE 2
`define PSL_STAT_SUPPLY_UP 3
`define PSL_SLEW_LSB 0
`define PSL_MODE_B3 4
`define PSL_MODE_B4 5
`define PSL_MODE_B6 6
`define PSL_MODE_B7 7
`define PSL_USR_LSB 4
`define PSL_MAX_LOAD_CURRENT_LSB 8
`define PSL_RAMP_LSB 4
`define PSL_ADDR_LSB 4
`define PSL_RST_SLEW 3'h1
`define PSL_RST_MODE 4'h9
`define PSL_RST_OSR 3'h7
`define PSL_RST_USR 3'h7
`define PSL_RST_BOOT 8'h97
`define PSL_RST_RISE 2'h0
`define PSL_RST_FREQ 3'h2
`define PSL_RST_MAX_LOAD_CURRENT 8'h78
`define PSL_RST_LIMIT 4'h8
`define PSL_RST_RAMP 2'h3
`define PSL_SETTLE_NS 1000
`define PSL_CLK_NS 10
// settle count in pclk cycles: 1000 ns at a 10 ns clock, sized for the 8-bit counter
`define PSL_SETTLE_CYC 8'h64
`endif

// [hw/psl_supply_detect.v]
// detects the logic supply coming up and emits one capture pulse once it has settled, and one more after each rearm while it stays up
`timescale 1ns/1ps
`include "psl_defs.vh"
module psl_supply_detect (
  input wire pclk,
  input wire presetn,
  input wire supply_good,
  input wire rearm,
  output reg capture_pulse,
  output reg supply_up
);
  reg [7:0] settle_reg;
  reg armed_reg;
  localparam [7:0] SETTLE = `PSL_SETTLE_CYC;
  // the pin is synchronous; a settle count filters a bouncing supply-good
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_reg <= 8'h00;
      armed_reg <= 1'b1;
      capture_pulse <= 1'b0;
      supply_up <= 1'b0;
    end else begin
      capture_pulse <= 1'b0;
      if (!supply_good) begin
        settle_reg <= 8'h00;
        armed_reg <= 1'b1;
        supply_up <= 1'b0;
      end else if (settle_reg != SETTLE) begin
        settle_reg <= settle_reg + 8'h01;
      end else begin
        supply_up <= 1'b1;
        if (armed_reg) begin
          capture_pulse <= 1'b1;
          armed_reg <= 1'b0;
        end
      end
      if (rearm) begin
        armed_reg <= 1'b1;
      end
    end
  end
endmodule // psl_supply_detect

// [dv/psl_strap_latch_asserts.sv]
// concurrent checks on the strap latch ports
`timescale 1ns/1ps
module psl_strap_latch_asserts (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pready,
  input logic pslverr,
  input logic strap_source_select,
  input logic [2:0] rate_mode_res_code,
  input logic [3:0] rate_mode_volt_code,
  input logic [3:0] address_and_rise_strap_volt,
  input logic [7:0] frequency_and_current_strap_volt,
  input logic [2:0] limit_and_ramp_strap_res,
  input logic [1:0] limit_and_ramp_strap_volt,
  input logic [2:0] slew_rate_sel,
  input logic [3:0] mode_bits,
  input logic [3:0] bus_address,
  input logic [7:0] max_load_current,
  input logic [3:0] per_phase_valley_limit,
  input logic [1:0] ramp_level,
  input logic config_valid
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////
  // only the first capture after reset is judged; straps are steady around it
  sequence cap_s; !config_valid ##1 config_valid; endsequence
  sequence strap_cap_s; cap_s ##0 !strap_source_select; endsequence
  sequence acc_s; psel && penable && !pready; endsequence
  ////////////////////////////////////////////////////////////////
  slew_cap_a: assert property (strap_cap_s |-> slew_rate_sel == rate_mode_res_code)
    else $error("slew rate not captured");
  mode_cap_a: assert property (strap_cap_s |-> mode_bits == rate_mode_volt_code)
    else $error("mode bits not captured");
  addr_cap_a: assert property (cap_s |-> bus_address == address_and_rise_strap_volt)
    else $error("bus address not captured");
  max_load_current_cap_a: assert property (strap_cap_s |-> max_load_current == frequency_and_current_strap_volt)
    else $error("max current not captured");
  limit_cap_a: assert property (strap_cap_s |->
    per_phase_valley_limit == {limit_and_ramp_strap_res, limit_and_ramp_strap_volt[1]})
    else $error("limit level not captured");
  ramp_cap_a: assert property (strap_cap_s |-> ramp_level == limit_and_ramp_strap_volt)
    else $error("ramp level not captured");
  addr_hold_a: assert property ($past(config_valid) |-> $stable(bus_address))
    else $error("bus address moved after capture");
  apb_answer_a: assert property (acc_s |=> pready)
    else $error("bus access not answered");
  ready_cause_a: assert property (pready |-> $past(psel && penable))
    else $error("ready without access");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
endmodule // psl_strap_latch_asserts
bind psl_strap_latch psl_strap_latch_asserts u_chk (.*);

// [dv/psl_strap_model.sv]
// strap divider model: presents each strap's resistor and voltage code
`timescale 1ns/1ps
module psl_strap_model (
  input wire logic [42:0] cd,
  output wire logic [2:0] rate_mode_res_code,
  output wire logic [3:0] rate_mode_volt_code,
  output wire logic [2:0] shoot_reduction_strap_res,
  output wire logic [2:0] shoot_reduction_strap_volt,
  output wire logic [2:0] startup_voltage_strap_res,
  output wire logic [3:0] startup_voltage_strap_volt,
  output wire logic [2:0] address_and_rise_strap_res,
  output wire logic [3:0] address_and_rise_strap_volt,
  output wire logic [2:0] frequency_and_current_strap_res,
  output wire logic [7:0] frequency_and_current_strap_volt,
  output wire logic [2:0] limit_and_ramp_strap_res,
  output wire logic [1:0] limit_and_ramp_strap_volt
);
  // dividers are static levels with no clock; the bench moves them after capture
  assign {rate_mode_res_code, rate_mode_volt_code, shoot_reduction_strap_res, shoot_reduction_strap_volt,
    startup_voltage_strap_res, startup_voltage_strap_volt, address_and_rise_strap_res,
    address_and_rise_strap_volt, frequency_and_current_strap_res, frequency_and_current_strap_volt,
    limit_and_ramp_strap_res, limit_and_ramp_strap_volt} = cd;
endmodule // psl_strap_model

// [dv/psl_strap_latch_tb_top.sv]
// self-checking bench for the strap latch
`timescale 1ns/1ps
module psl_strap_latch_tb_top;
  logic pclk, presetn, psel, penable, pwrite, logic_supply_rail, strap_source_select, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, q, d;
  logic [42:0] cd;
  logic [39:0] nv;
  logic [31:0] m [6];
  logic [31:0] rv [6] = '{32'h91, 32'h77, 32'h97, 32'h0, 32'h7802, 32'h38};
  logic [31:0] wm [6] = '{32'hF7, 32'h77, 32'hFF, 32'h3, 32'hFF07, 32'h3F};
  int error_cnt = 0, compares = 0, r, i, n;
  wire [31:0] prdata;
  wire pready, pslverr, config_valid;
  wire [2:0] rate_mode_res_code, shoot_reduction_strap_res, shoot_reduction_strap_volt, startup_voltage_strap_res;
  wire [2:0] address_and_rise_strap_res, frequency_and_current_strap_res, limit_and_ramp_strap_res;
  wire [2:0] nvm_slew, nvm_osr, nvm_usr, nvm_freq, slew_rate_sel, overshoot_reduction, undershoot_reduction;
  wire [2:0] switching_freq_sel;
  wire [3:0] rate_mode_volt_code, startup_voltage_strap_volt, address_and_rise_strap_volt, nvm_mode, nvm_limit;
  wire [3:0] mode_bits, bus_address, per_phase_valley_limit;
  wire [7:0] frequency_and_current_strap_volt, nvm_boot, nvm_max_load_current, voltage_id_code, max_load_current;
  wire [1:0] limit_and_ramp_strap_volt, nvm_rise, nvm_ramp, softstart_rise_rate, ramp_level;
  assign {nvm_slew, nvm_mode, nvm_osr, nvm_usr, nvm_boot, nvm_rise, nvm_freq, nvm_max_load_current, nvm_limit, nvm_ramp} = nv;
  psl_strap_model sm (.*);
  psl_strap_latch dut (.*);
`define CK(a, b) begin compares++; if ((a) !== (b)) begin error_cnt++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (a), (b)); end end
  always #5 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) error_cnt++;
  endtask
  // reference words per register, from straps or from the memory copy
  task calc;
    logic s;
    s = strap_source_select;
    m[0] = s ? {nv[36:33], 1'b0, nv[39:37]} : {cd[39:36], 1'b0, cd[42:40]};
    m[1] = s ? {nv[29:27], 1'b0, nv[32:30]} : {cd[32:30], 1'b0, cd[35:33]};
    m[2] = s ? nv[26:19] : {cd[26:23], cd[29:27], cd[20]};
    m[3] = {cd[19:16], 2'b0, s ? nv[18:17] : cd[22:21]};
    m[4] = s ? {nv[13:6], 5'b0, nv[16:14]} : {cd[12:5], 5'b0, cd[15:13]};
    m[5] = s ? {nv[1:0], nv[5:2]} : {cd[1:0], cd[4:2], cd[1]};
  endtask
  task chk_all;
    for (i = 0; i < 6; i++) begin
      apb(1'b0, 12'h008 + 12'(4 * i), 32'h0);
      `CK(q, m[i])
    end
    `CK(slew_rate_sel, m[0][2:0])
    `CK(mode_bits, m[0][7:4])
    `CK(overshoot_reduction, m[1][2:0])
    `CK(undershoot_reduction, m[1][6:4])
    `CK(voltage_id_code, m[2][7:0])
    `CK(softstart_rise_rate, m[3][1:0])
    `CK(bus_address, m[3][7:4])
    `CK(switching_freq_sel, m[4][2:0])
    `CK(max_load_current, m[4][15:8])
    `CK(per_phase_valley_limit, m[5][3:0])
    `CK(ramp_level, m[5][5:4])
  endtask
  task complete_run;
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // four rounds of roughly 330 cycles each; the 30000-cycle limit is a wide margin
  initial begin
    #300000;
    error_cnt++;
    complete_run();
  end
  initial begin
    pclk = 0;
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    logic_supply_rail = 0;
    strap_source_select = 0;
    cd = 0;
    nv = 0;
    void'($urandom(32'h4C2D30A9));
    for (r = 0; r < 4; r++) begin
      @(posedge pclk);
      presetn <= 1'b0;
      logic_supply_rail <= 1'b0;
      strap_source_select <= (r == 3);
      cd <= 43'({$urandom, $urandom});
      nv <= 40'({$urandom, $urandom});
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      // every mode bit takes both values over the rounds
      cd[39:36] <= {r[1], r[0], ~r[1], ~r[0]};
      m = rv;
      chk_all();
      `CK(config_valid, 1'b0)
      calc();
      logic_supply_rail <= 1'b1;
      n = 0;
      while (config_valid !== 1'b1 && n < 400) begin
        @(posedge pclk);
        n++;
      end
      `CK(config_valid, 1'b1)
      chk_all();
      if (r == 3) `CK(slew_rate_sel, nv[39:37])
      cd <= ~cd;
      repeat (20) @(posedge pclk);
      chk_all();
      for (i = 0; i < 6; i++) begin
        d = $urandom;
        apb(1'b1, 12'h008 + 12'(4 * i), d);
        `CK(e, 1'b0)
        m[i] = (m[i] & ~wm[i]) | (d & wm[i]);
      end
      chk_all();
      apb(1'b1, 12'h004, 32'hF);
      `CK(e, 1'b1)
      apb(1'b0, 12'h100, 32'h0);
      `CK(e, 1'b1)
      `CK(q, 32'h0)
      chk_all();
      apb(1'b0, 12'h004, 32'h0);
      `CK(q, {28'h0, 2'b11, strap_source_select, 1'b1})
      apb(1'b0, 12'h020, 32'h0);
      `CK(q, {12'h0, cd[19:16], cd[12:5], 2'b0, cd[1:0], 1'b0, cd[4:2]})
      // straps back to the captured levels, then ask for a fresh capture over the bus
      cd <= ~cd;
      apb(1'b1, 12'h000, 32'h1);
      `CK(e, 1'b0)
      repeat (10) @(posedge pclk);
      calc();
      chk_all();
      apb(1'b0, 12'h004, 32'h0);
      `CK(q, {28'h0, 2'b10, strap_source_select, 1'b1})
    end
    complete_run();
  end
endmodule // psl_strap_latch_tb_top
